// *** flash_rewrite_bus_timing_defs.vh ***
// Behaviour
// - In rewrite mode CPU flash accesses go over the dedicated rewrite bus.
// - CPU keeps running during program or erase; only bus cycles stall it.
// - After program or erase ends, flash reads return status, not array.
// - Status visible in status register and via read-status command.
// - In expansion mode timing registers alias external bus area 0/3 regs.
// - All rewrite bus phases counted in base clock cycles from the divider.
// - Multiplier code 10b means 3, code 11b means 4.
// - Read width codes 0000,0001,0101,0110,1010,1011,1111 mean wr 1..7.
// - Multiplier 3, no extension: read cycle 4,8,10,14,16,20,22.
// - Multiplier 3 with extension: odd wr gain two cycles, even unchanged.
// - Read setup one base cycle, strobe one shorter than read cycle, hold zero.
// - Write setup codes give weight 0..2; width codes give weight 1..4.
// - Multiplier 3: write strobe 3 per width step, setup 1, 4 or 7.
// - Multiplier 4: write strobe 4 per step, setup 1, 5 or 9, hold 1.
// - Multiplier 3, setup 0: write cycle 6, 8, 12 or 14.
// - Extension bit zero means no read pulse extension.
`ifndef FLASH_REWRITE_BUS_TIMING_DEFS_VH
`define FLASH_REWRITE_BUS_TIMING_DEFS_VH

// ****************************************
// Timing register fields
// ****************************************
`define FRB_WIDTH_LSB 0
`define FRB_WIDTH_MSB 3
`define FRB_EXTEND_BIT 4
`define FRB_SETUP_LSB 8
`define FRB_SETUP_MSB 9
`define FRB_WW_LSB 10
`define FRB_WW_MSB 11
`define FRB_MPY_LSB 12
`define FRB_MPY_MSB 13
`define FRB_TIMING_RESET 16'h0000
`define FRB_MPY4 2'b11

// ****************************************
// Read width encodings
// ****************************************
`define FRB_WR1 4'h0
`define FRB_WR2 4'h1
`define FRB_WR3 4'h5
`define FRB_WR4 4'h6
`define FRB_WR5 4'ha
`define FRB_WR6 4'hb
`define FRB_WR7 4'hf

// ****************************************
// Phase states, one-hot
// ****************************************
`define FRB_ST_IDLE 4'h1
`define FRB_ST_SETUP 4'h2
`define FRB_ST_STROBE 4'h4
`define FRB_ST_HOLD 4'h8

// ****************************************
// Status register layout and counter constants
// ****************************************
`define FRB_STAT_READY_BIT 7
`define FRB_STAT_ERASE_ERR_BIT 5
`define FRB_STAT_PROG_ERR_BIT 4
`define FRB_CNT_ONE 5'h01
`define FRB_CNT_TWO 5'h02

`endif

// *** flash_rewrite_bus_timing.v ***
`timescale 1ns/1ps
`include "flash_rewrite_bus_timing_defs.vh"

module flash_rewrite_bus_timing #(
   parameter ADDR_W = 24,
   parameter DATA_W = 16
)(
   input wire sys_clk_i,
   input wire reset_i,
   input wire ram_exec_rewrite_mode_i,
   input wire mem_expansion_i,
   input wire [1:0] base_clock_divider_i,
   input wire timing_wr_i,
   input wire timing_sel_i,
   input wire [15:0] timing_wdata_i,
   input wire ext_bus_wr_i,
   input wire ext_bus_sel_i,
   input wire [15:0] ext_bus_wdata_i,
   input wire cpu_req_i,
   input wire cpu_we_i,
   input wire cpu_data_area_i,
   input wire [ADDR_W-1:0] cpu_addr_i,
   input wire [DATA_W-1:0] cpu_wdata_i,
   input wire read_status_cmd_i,
   input wire read_array_cmd_i,
   input wire flash_busy_i,
   input wire [1:0] flash_err_i,
   input wire [DATA_W-1:0] fl_rdata_i,
   output reg rewrite_bus_sel_o,
   output reg cpu_busy_o,
   output reg cpu_done_o,
   output reg [DATA_W-1:0] cpu_rdata_o,
   output reg [15:0] rewrite_bus_timing_prog_o,
   output reg [15:0] rewrite_bus_timing_data_o,
   output reg [15:0] ext_bus_ctrl_area0_o,
   output reg [15:0] ext_bus_ctrl_area3_o,
   output reg [7:0] flash_status_reg_o,
   output reg read_status_mode_o,
   output reg fl_cs_n_o,
   output reg fl_rd_n_o,
   output reg fl_wr_n_o,
   output reg [ADDR_W-1:0] fl_addr_o,
   output reg [DATA_W-1:0] fl_wdata_o
);

   // ****************************************
   // Timing arithmetic
   // ****************************************
   function [2:0] wr_decode;
      input [3:0] sel;
      begin
         case (sel)
            `FRB_WR2: wr_decode = 3'h2;
            `FRB_WR3: wr_decode = 3'h3;
            `FRB_WR4: wr_decode = 3'h4;
            `FRB_WR5: wr_decode = 3'h5;
            `FRB_WR6: wr_decode = 3'h6;
            `FRB_WR7: wr_decode = 3'h7;
            default: wr_decode = 3'h1;
         endcase
      end
   endfunction
   // Codes other than 11b behave as multiplier 3
   function [2:0] mpy_of;
      input [1:0] code;
      begin
         mpy_of = (code == `FRB_MPY4) ? 3'h4 : 3'h3;
      end
   endfunction
   function [4:0] read_len;
      input [15:0] t;
      reg [4:0] wr;
      begin
         wr = {2'b00, wr_decode(t[`FRB_WIDTH_MSB:`FRB_WIDTH_LSB])};
         if (t[`FRB_MPY_MSB:`FRB_MPY_LSB] == `FRB_MPY4)
            read_len = (wr << 2) + `FRB_CNT_TWO;
         else
            read_len = wr + wr + wr + `FRB_CNT_ONE +
               {3'b000, wr[0] && t[`FRB_EXTEND_BIT], !wr[0]};
      end
   endfunction
   function [4:0] wsetup_len;
      input [15:0] t;
      reg [4:0] m;
      begin
         m = {2'b00, mpy_of(t[`FRB_MPY_MSB:`FRB_MPY_LSB])};
         wsetup_len = m * {3'b000, t[`FRB_SETUP_MSB:`FRB_SETUP_LSB]} +
            `FRB_CNT_ONE;
      end
   endfunction
   function [4:0] wwidth_len;
      input [15:0] t;
      reg [4:0] m;
      begin
         m = {2'b00, mpy_of(t[`FRB_MPY_MSB:`FRB_MPY_LSB])};
         wwidth_len = m * ({3'b000, t[`FRB_WW_MSB:`FRB_WW_LSB]} +
            `FRB_CNT_ONE);
      end
   endfunction
   // Multiplier 3 hold alternates so the cycle lands on an even count
   function [4:0] whold_len;
      input [15:0] t;
      begin
         whold_len = ((t[`FRB_MPY_MSB:`FRB_MPY_LSB] == `FRB_MPY4) ||
            (t[`FRB_SETUP_LSB] ^ t[`FRB_WW_LSB])) ?
            `FRB_CNT_ONE : `FRB_CNT_TWO;
      end
   endfunction

   // ****************************************
   // Base clock tick
   // ****************************************
   reg [1:0] div_cnt;
   reg base_tick;
   wire [1:0] div_last = ~base_clock_divider_i;
   always @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         div_cnt <= 2'b00;
         base_tick <= 1'b0;
      end
      else
      begin
         base_tick <= (div_cnt == div_last);
         div_cnt <= (div_cnt == div_last) ? 2'b00 : div_cnt + 2'b01;
      end
   end

   // ****************************************
   // Timing registers and external alias
   // ****************************************
   wire prog_wr = (timing_wr_i && !timing_sel_i) ||
      (ext_bus_wr_i && !ext_bus_sel_i && mem_expansion_i);
   wire data_wr = (timing_wr_i && timing_sel_i) ||
      (ext_bus_wr_i && ext_bus_sel_i && mem_expansion_i);
   wire [15:0] next_prog = timing_wr_i ? timing_wdata_i : ext_bus_wdata_i;
   wire [15:0] next_data = next_prog;
   reg [15:0] ext_area0_own;
   reg [15:0] ext_area3_own;
   always @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rewrite_bus_timing_prog_o <= `FRB_TIMING_RESET;
         rewrite_bus_timing_data_o <= `FRB_TIMING_RESET;
         ext_area0_own <= `FRB_TIMING_RESET;
         ext_area3_own <= `FRB_TIMING_RESET;
         ext_bus_ctrl_area0_o <= `FRB_TIMING_RESET;
         ext_bus_ctrl_area3_o <= `FRB_TIMING_RESET;
      end
      else
      begin
         if (prog_wr)
            rewrite_bus_timing_prog_o <= next_prog;
         if (data_wr)
            rewrite_bus_timing_data_o <= next_data;
         if (ext_bus_wr_i && !ext_bus_sel_i)
            ext_area0_own <= ext_bus_wdata_i;
         if (ext_bus_wr_i && ext_bus_sel_i)
            ext_area3_own <= ext_bus_wdata_i;
         // Shared address: timing write alters the area control
         ext_bus_ctrl_area0_o <= mem_expansion_i ?
            (prog_wr ? next_prog : rewrite_bus_timing_prog_o) :
            ext_area0_own;
         ext_bus_ctrl_area3_o <= mem_expansion_i ?
            (data_wr ? next_data : rewrite_bus_timing_data_o) :
            ext_area3_own;
      end
   end

   // ****************************************
   // Status and read-status mode
   // ****************************************
   reg busy_q;
   always @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         busy_q <= 1'b0;
         read_status_mode_o <= 1'b0;
         flash_status_reg_o <= 8'h00;
      end
      else
      begin
         busy_q <= flash_busy_i;
         flash_status_reg_o <= 8'h00;
         flash_status_reg_o[`FRB_STAT_READY_BIT] <= !flash_busy_i;
         flash_status_reg_o[`FRB_STAT_ERASE_ERR_BIT] <= flash_err_i[1];
         flash_status_reg_o[`FRB_STAT_PROG_ERR_BIT] <= flash_err_i[0];
         // Completion beats a same-cycle read-array command
         if ((busy_q && !flash_busy_i) || read_status_cmd_i)
            read_status_mode_o <= 1'b1;
         else if (read_array_cmd_i)
            read_status_mode_o <= 1'b0;
      end
   end

   // ****************************************
   // Phase sequencer
   // ****************************************
   reg [3:0] state;
   reg [4:0] cnt;
   reg is_write;
   reg [4:0] strobe_len;
   reg [4:0] hold_len;
   wire [15:0] sel_t = cpu_data_area_i ? rewrite_bus_timing_data_o :
      rewrite_bus_timing_prog_o;
   wire last = base_tick && (cnt == `FRB_CNT_ONE);

   always @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state <= `FRB_ST_IDLE;
         cnt <= 5'h00;
         is_write <= 1'b0;
         strobe_len <= 5'h00;
         hold_len <= 5'h00;
         rewrite_bus_sel_o <= 1'b0;
         cpu_busy_o <= 1'b0;
         cpu_done_o <= 1'b0;
         cpu_rdata_o <= {DATA_W{1'b0}};
         fl_cs_n_o <= 1'b1;
         fl_rd_n_o <= 1'b1;
         fl_wr_n_o <= 1'b1;
         fl_addr_o <= {ADDR_W{1'b0}};
         fl_wdata_o <= {DATA_W{1'b0}};
      end
      else
      begin
         rewrite_bus_sel_o <= ram_exec_rewrite_mode_i;
         cpu_done_o <= 1'b0;
         if (base_tick && cnt != 5'h00)
            cnt <= cnt - `FRB_CNT_ONE;
         case (state)
            `FRB_ST_IDLE:
            begin
               // Taken on a base tick so setup is a whole base cycle
               if (cpu_req_i && ram_exec_rewrite_mode_i &&
                  base_tick)
               begin
                  state <= `FRB_ST_SETUP;
                  is_write <= cpu_we_i;
                  cpu_busy_o <= 1'b1;
                  fl_cs_n_o <= 1'b0;
                  fl_addr_o <= cpu_addr_i;
                  fl_wdata_o <= cpu_wdata_i;
                  // Read: setup is one base cycle, strobe one less than the cycle
                  cnt <= cpu_we_i ? wsetup_len(sel_t) : `FRB_CNT_ONE;
                  strobe_len <= cpu_we_i ? wwidth_len(sel_t) :
                     read_len(sel_t) - `FRB_CNT_ONE;
                  hold_len <= whold_len(sel_t);
               end
            end
            `FRB_ST_SETUP:
               if (last)
               begin
                  state <= `FRB_ST_STROBE;
                  cnt <= strobe_len;
                  fl_rd_n_o <= is_write;
                  fl_wr_n_o <= !is_write;
               end
            `FRB_ST_STROBE:
               if (last)
               begin
                  fl_rd_n_o <= 1'b1;
                  fl_wr_n_o <= 1'b1;
                  if (is_write)
                  begin
                     state <= `FRB_ST_HOLD;
                     cnt <= hold_len;
                  end
                  else
                  begin
                     state <= `FRB_ST_IDLE;
                     fl_cs_n_o <= 1'b1;
                     cpu_busy_o <= 1'b0;
                     cpu_done_o <= 1'b1;
                     cpu_rdata_o <= read_status_mode_o ?
                        {{(DATA_W-8){1'b0}}, flash_status_reg_o} :
                        fl_rdata_i;
                  end
               end
            `FRB_ST_HOLD:
               if (last)
               begin
                  state <= `FRB_ST_IDLE;
                  fl_cs_n_o <= 1'b1;
                  cpu_busy_o <= 1'b0;
                  cpu_done_o <= 1'b1;
               end
            default:
               state <= `FRB_ST_IDLE;
         endcase
      end
   end

endmodule

// *** flash_array_model.sv ***
`timescale 1ns/1ps
module flash_array_model (
   input wire clk_i,
   input wire cs_n_i,
   input wire rd_n_i,
   input wire wr_n_i,
   input wire [23:0] addr_i,
   input wire [15:0] wdata_i,
   output wire [15:0] rdata_o
);
   // ********
   // Array side
   // ********
   reg flip = 1'b0;
   reg [15:0] last_wdata = 16'h0000;
   always @(posedge clk_i)
      flip <= ~flip;
   // Released bus toggles so a late sample never looks right
   assign rdata_o = (!cs_n_i && !rd_n_i) ? addr_i[15:0] ^ 16'h5a5a :
      {16{flip}};
   always @(posedge wr_n_i)
      if (!cs_n_i)
         last_wdata <= wdata_i;
endmodule

// *** flash_rewrite_bus_timing_monitor.sv ***
`timescale 1ns/1ps
module flash_rewrite_bus_timing_monitor (
   input wire sys_clk_i,
   input wire reset_i,
   input wire ram_exec_rewrite_mode_i,
   input wire mem_expansion_i,
   input wire timing_wr_i,
   input wire timing_sel_i,
   input wire [15:0] timing_wdata_i,
   input wire flash_busy_i,
   input wire rewrite_bus_sel_o,
   input wire cpu_done_o,
   input wire [15:0] ext_bus_ctrl_area0_o,
   input wire [7:0] flash_status_reg_o,
   input wire read_status_mode_o,
   input wire fl_cs_n_o,
   input wire fl_rd_n_o,
   input wire fl_wr_n_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   route_follow_a: assert property (ram_exec_rewrite_mode_i[*2] |->
      rewrite_bus_sel_o) else $error("rewrite bus not selected");
   strobe_in_cs_a: assert property ((!fl_rd_n_o || !fl_wr_n_o) |->
      !fl_cs_n_o) else $error("strobe without select");
   one_strobe_a: assert property (fl_rd_n_o || fl_wr_n_o)
      else $error("read and write strobes together");
   done_pulse_a: assert property (cpu_done_o |=> !cpu_done_o)
      else $error("done longer than one cycle");
   read_hold_a: assert property ($rose(fl_rd_n_o) |->
      $rose(fl_cs_n_o) && cpu_done_o) else $error("read hold not zero");
   read_setup_a: assert property ($fell(fl_rd_n_o) |->
      $past(fl_cs_n_o) == 1'b0) else $error("no read setup");
   write_hold_a: assert property ($rose(fl_wr_n_o) |-> !fl_cs_n_o)
      else $error("no write hold");
   ready_bit_a: assert property (!flash_busy_i[*2] |->
      flash_status_reg_o[7]) else $error("ready bit low when idle");
   status_mode_a: assert property ($fell(flash_busy_i) |-> ##[1:2]
      read_status_mode_o) else $error("no read status mode");
   alias_a: assert property (mem_expansion_i && timing_wr_i && !timing_sel_i
      |=> ext_bus_ctrl_area0_o == $past(timing_wdata_i))
      else $error("area0 alias not updated");
endmodule
bind flash_rewrite_bus_timing flash_rewrite_bus_timing_monitor u_mon (
   .sys_clk_i, .reset_i, .ram_exec_rewrite_mode_i, .mem_expansion_i,
   .timing_wr_i, .timing_sel_i, .timing_wdata_i, .flash_busy_i,
   .rewrite_bus_sel_o, .cpu_done_o, .ext_bus_ctrl_area0_o,
   .flash_status_reg_o, .read_status_mode_o, .fl_cs_n_o, .fl_rd_n_o,
   .fl_wr_n_o);

// *** flash_rewrite_bus_timing_tb_top.sv ***
`timescale 1ns/1ps
module flash_rewrite_bus_timing_tb_top;
   reg sys_clk_i = 1'b0, reset_i = 1'b1, ram_exec_rewrite_mode_i = 1'b1;
   reg mem_expansion_i = 1'b0, timing_wr_i = 1'b0, timing_sel_i = 1'b0;
   reg ext_bus_wr_i = 1'b0, ext_bus_sel_i = 1'b1, cpu_req_i = 1'b0;
   reg cpu_we_i = 1'b0, cpu_data_area_i = 1'b0, flash_busy_i = 1'b0;
   reg read_status_cmd_i = 1'b0, read_array_cmd_i = 1'b0;
   reg [1:0] base_clock_divider_i = 2'b11, flash_err_i = 2'b00;
   reg [15:0] timing_wdata_i = 16'h0000, ext_bus_wdata_i = 16'h0000;
   reg [15:0] cpu_wdata_i = 16'h0000;
   reg [23:0] cpu_addr_i = 24'h000000;
   reg [27:0] codes = 28'hfba6510;
   wire [15:0] fl_rdata_i, cpu_rdata_o, fl_wdata_o, ext_bus_ctrl_area3_o;
   wire [15:0] rewrite_bus_timing_prog_o, rewrite_bus_timing_data_o;
   wire [15:0] ext_bus_ctrl_area0_o;
   wire [7:0] flash_status_reg_o;
   wire [23:0] fl_addr_o;
   wire rewrite_bus_sel_o, cpu_busy_o, cpu_done_o, read_status_mode_o;
   wire fl_cs_n_o, fl_rd_n_o, fl_wr_n_o;
   integer num_errors = 0, check_count = 0;
   integer n_cs = 0, n_str = 0, n_pre = 0, i, j, m, r;
   always #12.5 sys_clk_i = ~sys_clk_i;
   flash_rewrite_bus_timing u_flash_rewrite_bus_timing (.sys_clk_i,
      .reset_i, .ram_exec_rewrite_mode_i, .mem_expansion_i,
      .base_clock_divider_i, .timing_wr_i, .timing_sel_i, .timing_wdata_i,
      .ext_bus_wr_i, .ext_bus_sel_i, .ext_bus_wdata_i, .cpu_req_i,
      .cpu_we_i, .cpu_data_area_i, .cpu_addr_i, .cpu_wdata_i,
      .read_status_cmd_i, .read_array_cmd_i, .flash_busy_i, .flash_err_i,
      .fl_rdata_i, .rewrite_bus_sel_o, .cpu_busy_o, .cpu_done_o,
      .cpu_rdata_o, .rewrite_bus_timing_prog_o, .rewrite_bus_timing_data_o,
      .ext_bus_ctrl_area0_o, .ext_bus_ctrl_area3_o, .flash_status_reg_o,
      .read_status_mode_o, .fl_cs_n_o, .fl_rd_n_o, .fl_wr_n_o, .fl_addr_o,
      .fl_wdata_o);
   flash_array_model u_flash_array_model (.clk_i(sys_clk_i),
      .cs_n_i(fl_cs_n_o), .rd_n_i(fl_rd_n_o), .wr_n_i(fl_wr_n_o),
      .addr_i(fl_addr_o), .wdata_i(fl_wdata_o), .rdata_o(fl_rdata_i));
   // ********
   // Phase counters, sampled mid-cycle
   // ********
   always @(negedge sys_clk_i)
      if (fl_cs_n_o === 1'b0)
      begin
         n_cs = n_cs + 1;
         if (!fl_rd_n_o || !fl_wr_n_o)
            n_str = n_str + 1;
         else if (n_str == 0)
            n_pre = n_pre + 1;
      end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   task set_t(input [15:0] t);
   begin
      @(negedge sys_clk_i);
      timing_wdata_i = t;
      timing_wr_i = 1'b1;
      @(negedge sys_clk_i);
      timing_wr_i = 1'b0;
   end
   endtask
   // Request held until busy shows, since takes wait for a base tick
   task acc(input w);
      integer g;
   begin
      @(negedge sys_clk_i);
      n_cs = 0;
      n_str = 0;
      n_pre = 0;
      g = 0;
      cpu_we_i = w;
      cpu_req_i = 1'b1;
      @(negedge sys_clk_i);
      while (cpu_busy_o !== 1'b1 && g < 300)
      begin
         @(negedge sys_clk_i);
         g = g + 1;
      end
      cpu_req_i = 1'b0;
      while (cpu_done_o !== 1'b1 && g < 300)
      begin
         @(negedge sys_clk_i);
         g = g + 1;
      end
      if (g >= 300)
      begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   endtask
   // ********
   // Main sequence
   // ********
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      reset_i = 1'b0;
      chk(fl_cs_n_o, 1);
      chk(rewrite_bus_timing_prog_o, 0);
      for (m = 2; m < 4; m = m + 1)
         for (j = 0; j < 2; j = j + 1)
            for (i = 0; i < 7; i = i + 1)
            begin
               set_t({2'b00, m[1:0], 7'h00, j[0], codes[4*i +: 4]});
               cpu_addr_i = 24'h010000 + i * 24'h000111;
               acc(1'b0);
               r = (m == 3) ? 4 * i + 6 : (i % 2 == 1) ? 3 * i + 5 :
                  3 * i + 4 + 2 * j;
               chk(n_cs, r);
               chk(n_str, r - 1);
               chk(cpu_rdata_o, cpu_addr_i[15:0] ^ 16'h5a5a);
            end
      $display("read timing test done");
      for (m = 2; m < 4; m = m + 1)
         for (j = 0; j < 3; j = j + 1)
            for (i = 0; i < 4; i = i + 1)
            begin
               set_t({2'b00, m[1:0], i[1:0], j[1:0], 8'h00});
               cpu_wdata_i = 16'h3c00 + check_count[15:0];
               acc(1'b1);
               r = (m == 3 || j[0] != i[0]) ? 1 : 2;
               chk(n_pre, 1 + (m + 1) * j);
               chk(n_str, (m + 1) * (i + 1));
               chk(n_cs, 1 + (m + 1) * (i + j + 1) + r);
               chk(u_flash_array_model.last_wdata, cpu_wdata_i);
            end
      $display("write timing test done");
      base_clock_divider_i = 2'b00;
      set_t(16'h2000);
      acc(1'b0);
      chk(n_cs, 16);
      chk(n_str, 12);
      base_clock_divider_i = 2'b11;
      $display("base clock test done");
      ram_exec_rewrite_mode_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      n_cs = 0;
      cpu_req_i = 1'b1;
      repeat (10) @(negedge sys_clk_i);
      cpu_req_i = 1'b0;
      chk(n_cs, 0);
      chk(rewrite_bus_sel_o, 0);
      chk(cpu_busy_o, 0);
      ram_exec_rewrite_mode_i = 1'b1;
      $display("mode off test done");
      chk(ext_bus_ctrl_area0_o, 0);
      mem_expansion_i = 1'b1;
      set_t(16'h1234);
      chk(ext_bus_ctrl_area0_o, 16'h1234);
      ext_bus_wdata_i = 16'habcd;
      ext_bus_wr_i = 1'b1;
      @(negedge sys_clk_i);
      ext_bus_wr_i = 1'b0;
      @(negedge sys_clk_i);
      chk(rewrite_bus_timing_data_o, 16'habcd);
      chk(ext_bus_ctrl_area3_o, 16'habcd);
      chk(rewrite_bus_timing_prog_o, 16'h1234);
      mem_expansion_i = 1'b0;
      $display("alias test done");
      set_t(16'h2805);
      flash_err_i = 2'b11;
      flash_busy_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      chk(flash_status_reg_o, 8'h30);
      flash_busy_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk(read_status_mode_o, 1);
      acc(1'b0);
      chk(cpu_rdata_o, 16'h00b0);
      read_array_cmd_i = 1'b1;
      @(negedge sys_clk_i);
      read_array_cmd_i = 1'b0;
      acc(1'b0);
      chk(cpu_rdata_o, cpu_addr_i[15:0] ^ 16'h5a5a);
      chk(n_cs, 10);
      chk(n_str, 9);
      read_status_cmd_i = 1'b1;
      @(negedge sys_clk_i);
      read_status_cmd_i = 1'b0;
      @(negedge sys_clk_i);
      chk(read_status_mode_o, 1);
      $display("status test done");
      close_out;
   end
endmodule
